// ### rtl/usp_top.sv
`timescale 1ns/100ps
module usp_top
   import usp_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic nrst_in,
   input wire logic por_hold_in,
   input wire logic rst_pin_in,
   output logic rst_pin_out,
   output logic rst_pin_oe_out,
   output logic sys_rst_req_out,
   input wire logic vbus_in,
   output logic attached_out,
   input wire logic bus_suspend_in,
   input wire logic bus_resume_in,
   input wire logic self_resume_in,
   input wire logic bus_reset_in,
   input wire logic configured_in,
   output logic suspend_out,
   output logic suspend_n_out,
   input wire usp_modem_t modem_n_in,
   output usp_modem_t modem_out,
   input wire usp_mctl_t mctl_in,
   output usp_mctl_t mctl_n_out,
   input wire logic [GPIO_N-1:0] gpio_dir_in,
   input wire logic [GPIO_N-1:0] gpio_val_in,
   input wire logic [GPIO_N-1:0] gpio_pin_in,
   output logic [GPIO_N-1:0] gpio_pin_out,
   output logic [GPIO_N-1:0] gpio_oe_out,
   output logic [GPIO_N-1:0] gpio_rd_out
);

   // ---------------------------------------------------------------
   // Reset pin
   // ---------------------------------------------------------------
   // The pin is only ever pulled low; the level read back while not
   // driving is what an external party forces.
   logic [9:0] low_cnt_reg;
   logic ext_req;
   assign ext_req = (low_cnt_reg == EXT_RST_CYC_W);

   always_ff @(posedge sys_clk_in)
   begin
      rst_pin_out <= 1'b0;
      rst_pin_oe_out <= !nrst_in || por_hold_in;
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (!nrst_in || rst_pin_in || rst_pin_oe_out)
         low_cnt_reg <= 10'h000;
      else if (!ext_req)
         low_cnt_reg <= low_cnt_reg + 10'h001;
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (!nrst_in)
         sys_rst_req_out <= 1'b0;
      else
         sys_rst_req_out <= ext_req;
   end

   // ---------------------------------------------------------------
   // Suspend state
   // ---------------------------------------------------------------
   usp_state_t state_reg;
   usp_state_t state_next;
   logic leave;
   assign leave = bus_resume_in || self_resume_in || bus_reset_in;

   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         USP_UNCONF:
            if (configured_in)
               state_next = USP_ACTIVE;
         USP_ACTIVE:
            if (bus_suspend_in && !leave)
               state_next = USP_SUSP;
         USP_SUSP:
            if (leave)
               state_next = USP_ACTIVE;
         default:
            state_next = USP_UNCONF;
      endcase
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (!nrst_in || sys_rst_req_out)
         state_reg <= USP_UNCONF;
      else
         state_reg <= state_next;
   end

   // Both indicators are registered from the same state_next (SUSP_RST in reset) so they can never disagree.
   always_ff @(posedge sys_clk_in)
   begin
      if (!nrst_in || sys_rst_req_out)
      begin
         suspend_out <= SUSP_RST;
         suspend_n_out <= !SUSP_RST;
      end
      else
      begin
         suspend_out <= (state_next != USP_ACTIVE);
         suspend_n_out <= (state_next == USP_ACTIVE);
      end
   end

   // ---------------------------------------------------------------
   // Pins
   // ---------------------------------------------------------------
   // Transfers and the transceiver live in the function core outside;
   // this block only presents the pin polarity it depends on.
   always_ff @(posedge sys_clk_in)
   begin
      if (!nrst_in)
      begin
         attached_out <= 1'b0;
         modem_out <= '0;
         mctl_n_out <= '1;
         gpio_pin_out <= '0;
         gpio_oe_out <= '0;
         gpio_rd_out <= '0;
      end
      else
      begin
         attached_out <= vbus_in;
         modem_out <= ~modem_n_in;
         mctl_n_out <= ~mctl_in;
         gpio_pin_out <= gpio_val_in;
         gpio_oe_out <= gpio_dir_in;
         gpio_rd_out <= gpio_pin_in;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   sequence susp_entry_s;
      state_reg == USP_ACTIVE && bus_suspend_in && !leave && !sys_rst_req_out;
   endsequence

   susp_enter_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      susp_entry_s |=> suspend_out && !suspend_n_out)
      else $error("suspend not entered");
   susp_compl_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      ##1 suspend_out != suspend_n_out)
      else $error("indicators not complementary");
   susp_leave_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      state_reg == USP_SUSP && leave && !sys_rst_req_out |=> !suspend_out && suspend_n_out)
      else $error("suspend not left");
   unconf_hold_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      state_reg == USP_UNCONF && !configured_in |=> suspend_out)
      else $error("indicator dropped before configuration");
   rst_drive_a: assert property (@(posedge sys_clk_in)
      por_hold_in |=> rst_pin_oe_out && !rst_pin_out)
      else $error("reset pin not pulled low");
   // A request may only rise once the counter has seen the full low time,
   // and the counter must climb by one per low cycle from zero.
   sequence pin_low_s;
      !rst_pin_in && !rst_pin_oe_out && !ext_req;
   endsequence

   ext_rst_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      $rose(sys_rst_req_out) |-> $past(low_cnt_reg) == EXT_RST_CYC_W)
      else $error("reset request before full low time");
   ext_cnt_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      pin_low_s |=> low_cnt_reg == $past(low_cnt_reg) + 10'h001)
      else $error("low time not counted");
   ext_zero_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      rst_pin_in || rst_pin_oe_out |=> low_cnt_reg == 10'h000)
      else $error("low time not restarted");
   ext_drop_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      rst_pin_in |=> ##1 !sys_rst_req_out)
      else $error("reset request outlives pulse");
   rst_free_a: assert property (@(posedge sys_clk_in)
      nrst_in && !por_hold_in |=> !rst_pin_oe_out)
      else $error("reset pin held without cause");
   cfg_leave_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      state_reg == USP_UNCONF && configured_in && !sys_rst_req_out
         |=> !suspend_out && suspend_n_out)
      else $error("indicators kept after configuration");
   sys_rst_susp_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      sys_rst_req_out |=> suspend_out && !suspend_n_out && state_reg == USP_UNCONF)
      else $error("external reset did not restart");
   susp_hold_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      state_reg == USP_SUSP && !leave && !sys_rst_req_out |=> suspend_out && !suspend_n_out)
      else $error("suspend dropped without cause");
   active_hold_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      state_reg == USP_ACTIVE && !bus_suspend_in && !sys_rst_req_out
         |=> !suspend_out && suspend_n_out)
      else $error("suspend raised without cause");
   modem_pol_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      nrst_in |=> modem_out == ~$past(modem_n_in))
      else $error("modem input polarity wrong");
   mctl_pol_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      nrst_in |=> mctl_n_out == ~$past(mctl_in))
      else $error("modem output polarity wrong");
   vbus_att_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      nrst_in |=> attached_out == $past(vbus_in))
      else $error("attach not tracking sense");
   gpio_out_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      nrst_in |=> gpio_oe_out == $past(gpio_dir_in) && gpio_pin_out == $past(gpio_val_in))
      else $error("general pin drive wrong");
   gpio_rd_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      nrst_in |=> gpio_rd_out == $past(gpio_pin_in))
      else $error("general pin read wrong");
endmodule

// ### rtl/usp_pkg.sv
package usp_pkg;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_HZ = 20000000;
   localparam int EXT_RST_MIN_US = 15;
   localparam int EXT_RST_CYC = (EXT_RST_MIN_US * CLK_HZ + 999999) / 1000000;
   localparam logic [9:0] EXT_RST_CYC_W = EXT_RST_CYC[9:0];
   localparam int GPIO_N = 4;
   localparam logic SUSP_RST = 1'b1;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      USP_UNCONF = 2'b00,
      USP_ACTIVE = 2'b01,
      USP_SUSP = 2'b11
   } usp_state_t;

   typedef struct packed {
      logic cts;
      logic dsr;
      logic dcd;
      logic ri;
   } usp_modem_t;

   typedef struct packed {
      logic rts;
      logic dtr;
   } usp_mctl_t;
endpackage

// ### tb/usp_host_model.sv
`timescale 1ns/100ps
module usp_host_model
(
   input wire logic sys_clk_in,
   input wire logic [3:0] req_in,
   output logic [3:0] sig_out
);
   // ---------------------------------------------
   // Bus signalling
   // ---------------------------------------------
   // Each event lasts one clock, so a stuck level cannot hide a missed edge.
   always_ff @(posedge sys_clk_in)
      sig_out <= req_in;
endmodule

// ### tb/usp_top_bench.sv
`timescale 1ns/100ps
module usp_top_bench;
   import usp_pkg::*;
   logic sys_clk_in = 1'b0;
   logic nrst_in = 1'b0;
   logic por_hold_in = 1'b0;
   logic ext_low = 1'b0;
   logic vbus_in = 1'b0;
   logic self_resume_in = 1'b0;
   logic [3:0] req = 4'h0;
   usp_modem_t modem_n_in = 4'hF;
   usp_mctl_t mctl_in = 2'h0;
   logic [3:0] gpio_dir_in = 4'h0;
   logic [3:0] gpio_val_in = 4'h0;
   logic [3:0] gpio_pin_in = 4'h0;
   logic [3:0] ev, gpio_pin_out, gpio_oe_out, gpio_rd_out;
   logic rst_pin_out, rst_pin_oe_out, sys_rst_req_out, attached_out;
   logic suspend_out, suspend_n_out;
   logic bus_suspend_in, bus_resume_in, bus_reset_in, configured_in;
   usp_modem_t modem_out;
   usp_mctl_t mctl_n_out;
   int n_mismatch = 0;
   int checks_done = 0;
   // The reset pin has a pull-up; either party may pull it low.
   wire logic rst_pin_in = !(rst_pin_oe_out || ext_low);
   assign {configured_in, bus_reset_in, bus_resume_in, bus_suspend_in} = ev;
   always #25 sys_clk_in = ~sys_clk_in;
   usp_host_model host (.sys_clk_in(sys_clk_in), .req_in(req), .sig_out(ev));
   usp_top uut (
      .sys_clk_in(sys_clk_in),
      .nrst_in(nrst_in),
      .por_hold_in(por_hold_in),
      .rst_pin_in(rst_pin_in),
      .rst_pin_out(rst_pin_out),
      .rst_pin_oe_out(rst_pin_oe_out),
      .sys_rst_req_out(sys_rst_req_out),
      .vbus_in(vbus_in),
      .attached_out(attached_out),
      .bus_suspend_in(bus_suspend_in),
      .bus_resume_in(bus_resume_in),
      .self_resume_in(self_resume_in),
      .bus_reset_in(bus_reset_in),
      .configured_in(configured_in),
      .suspend_out(suspend_out),
      .suspend_n_out(suspend_n_out),
      .modem_n_in(modem_n_in),
      .modem_out(modem_out),
      .mctl_in(mctl_in),
      .mctl_n_out(mctl_n_out),
      .gpio_dir_in(gpio_dir_in),
      .gpio_val_in(gpio_val_in),
      .gpio_pin_in(gpio_pin_in),
      .gpio_pin_out(gpio_pin_out),
      .gpio_oe_out(gpio_oe_out),
      .gpio_rd_out(gpio_rd_out)
   );
   // ---------------------------------------------
   // Tasks
   // ---------------------------------------------
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      #1;
      checks_done++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic pulse(input logic [3:0] b, input logic s);
      @(posedge sys_clk_in);
      req <= b;
      self_resume_in <= s;
      @(posedge sys_clk_in);
      req <= 4'h0;
      self_resume_in <= 1'b0;
      repeat (2) @(posedge sys_clk_in);
   endtask
   task automatic t_config();
      pulse(4'h1, 1'b0);
      chk("susp unconf", 8'h2, {suspend_out, suspend_n_out});
      pulse(4'h4, 1'b0);
      chk("busrst unconf", 8'h2, {suspend_out, suspend_n_out});
      pulse(4'h8, 1'b0);
      chk("configured", 8'h1, {suspend_out, suspend_n_out});
   endtask
   task automatic t_susp();
      for (int i = 0; i < 3; i++)
      begin
         pulse(4'h1, 1'b0);
         chk("suspend", 8'h2, {suspend_out, suspend_n_out});
         pulse(i == 0 ? 4'h2 : i == 1 ? 4'h4 : 4'h0, i == 2);
         chk("leave", 8'h1, {suspend_out, suspend_n_out});
      end
   endtask
   task automatic t_pins();
      for (int i = 0; i < 16; i++)
      begin
         @(posedge sys_clk_in);
         modem_n_in <= i[3:0];
         mctl_in <= i[1:0];
         vbus_in <= i[0];
         gpio_dir_in <= i[3:0];
         gpio_val_in <= ~i[3:0];
         gpio_pin_in <= i[3:0];
         repeat (2) @(posedge sys_clk_in);
         chk("modem in", {4'h0, ~i[3:0]}, {4'h0, modem_out});
         chk("modem out", {6'h0, ~i[1:0]}, {6'h0, mctl_n_out});
         chk("attached", {7'h0, i[0]}, {7'h0, attached_out});
         chk("gpio", {i[3:0], ~i[3:0]}, {gpio_oe_out, gpio_pin_out});
         chk("gpio rd", {4'h0, i[3:0]}, {4'h0, gpio_rd_out});
      end
   endtask
   task automatic t_rstpin();
      @(posedge sys_clk_in);
      ext_low <= 1'b1;
      repeat (290) @(posedge sys_clk_in);
      chk("short pulse", 8'h0, {7'h0, sys_rst_req_out});
      repeat (15) @(posedge sys_clk_in);
      chk("long pulse", 8'h1, {7'h0, sys_rst_req_out});
      chk("susp rst", 8'h2, {suspend_out, suspend_n_out});
      @(posedge sys_clk_in);
      ext_low <= 1'b0;
      repeat (3) @(posedge sys_clk_in);
      chk("pulse end", 8'h0, {7'h0, sys_rst_req_out});
      @(posedge sys_clk_in);
      por_hold_in <= 1'b1;
      repeat (2) @(posedge sys_clk_in);
      chk("por drive", 8'h2, {6'h0, rst_pin_oe_out, rst_pin_out});
      @(posedge sys_clk_in);
      por_hold_in <= 1'b0;
      repeat (2) @(posedge sys_clk_in);
      chk("por free", 8'h0, {6'h0, rst_pin_oe_out, rst_pin_out});
   endtask
   task automatic give_verdict();
      $display("Mismatches %0d, checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial
   begin
      #150000;
      n_mismatch++;
      give_verdict();
   end
   initial
   begin
      repeat (12) @(posedge sys_clk_in);
      chk("reset drive", 8'h1, {7'h0, rst_pin_oe_out});
      chk("reset susp", 8'h2, {suspend_out, suspend_n_out});
      @(posedge sys_clk_in);
      nrst_in <= 1'b1;
      t_config();
      t_susp();
      t_pins();
      t_rstpin();
      give_verdict();
   end
endmodule
